// *** rtl/gcr_cfg.svh ***
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH
// Register offsets (byte addresses)
`define GCR_OFS_IDENT      8'h00
`define GCR_OFS_CTRL1      8'h02
`define GCR_OFS_CTRL2      8'h04
`define GCR_OFS_PINCTL     8'h0a
`define GCR_OFS_ISTAT      8'h10
`define GCR_OFS_IEN        8'h12
`define GCR_OFS_LIVE       8'h14
`define GCR_OFS_LATCH      8'h16
`define GCR_OFS_SIEN       8'h18
`define GCR_OFS_PINRD      8'h1c
// Control one fields
`define GCR_C1_IRQ_IDLE    14
`define GCR_C1_MAN_ERR     7
`define GCR_C1_ERR_SRC     6
`define GCR_C1_MODE_HI     5
`define GCR_C1_MODE_LO     4
`define GCR_C1_UPD_REQ     3
`define GCR_C1_CLR_POL     2
`define GCR_C1_DP_RST      1
`define GCR_C1_FULL_RST    0
// Control two fields
`define GCR_C2_SRC_HI      11
`define GCR_C2_SRC_LO      10
`define GCR_C2_OUT_SEL     9
`define GCR_C2_EXT_SEL     8
`define GCR_C2_RATE_HI     3
`define GCR_C2_RATE_LO     1
// Live status fields
`define GCR_SR_UPD_DONE    0
// Reset values and writable masks
`define GCR_C1_RESET       16'h0002
`define GCR_C1_MASK        16'h40ff
`define GCR_C2_RESET       16'h0000
`define GCR_C2_MASK        16'h0f0e
`define GCR_ZERO16         16'h0000
// Timing: least reset hold, 100 ns, in cycles at 25 MHz
`define GCR_RST_HOLD_NS    100
`define GCR_CLK_MHZ        25
`define GCR_RST_HOLD_CYC   ((`GCR_RST_HOLD_NS * `GCR_CLK_MHZ + 999) / 1000)
`endif

// *** rtl/gcr_pkg.sv ***
`default_nettype none
package gcr_pkg;
    // Performance-monitor update source
    typedef enum logic [1:0] {
        GCR_UPD_SOFT = 2'b00,
        GCR_UPD_PIN  = 2'b01,
        GCR_UPD_SEC  = 2'b10
    } gcr_upd_src_t;
    // Update handshake state
    typedef enum logic [1:0] {
        GCR_HS_IDLE = 2'b00,
        GCR_HS_BUSY = 2'b01,
        GCR_HS_DONE = 2'b10
    } gcr_hs_state_t;
endpackage : gcr_pkg
`default_nettype wire

// *** rtl/gcr_bank.sv ***
// Behaviour
// [R1] Identity top nibble mirrors scan revision
// [R2] Identity low twelve bits mirror part code
// [R3] Interrupt pin pulls low while active
// [R4] Control bit fourteen picks idle pin drive
// [R5] Trigger rising edge inserts one error
// [R6] Trigger ignored unless source select clear
// [R7] Source select picks trigger or pin six
// [R8] Mode field picks soft, pin eight, second
// [R9] Soft update rising edge loads and clears
// [R10] Done flag clears when update bit falls
// [R11] Policy bit picks clear on write/read
// [R12] Datapath reset bit holds datapath reset
// [R13] Datapath reset bit is one after reset
// [R14] Full reset defaults all but itself
// [R15] Software holds reset bits at least 100ns
// [R16] Source field selects 8k reference origin
// [R17] Source field ignored when external selected
// [R18] Source codes: off, adapter, port, undefined
// [R19] Pin four is reference when selected
// [R20] Rate adapter field encodes ref frequency
// [R21] Unused addresses read zero, ignore writes
`include "gcr_cfg.svh"
`default_nettype none
module gcr_bank
#(
    parameter logic [3:0]  SCAN_REVISION = 4'h1,   // Arbitrary value
    parameter logic [11:0] SCAN_PART     = 12'h0a5  // Arbitrary value
)
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    input  wire logic        i_irq_active,
    output logic             o_irq_out,
    output logic             o_irq_oe,
    input  wire logic        i_aux_pin_four,
    input  wire logic        i_aux_pin_six,
    input  wire logic        i_aux_pin_eight,
    input  wire logic        i_port_ref8k,
    input  wire logic        i_adapter_ref8k,
    input  wire logic        i_monitor_update_done,
    input  wire logic [15:0] i_interrupt_status,
    input  wire logic [15:0] i_live_status,
    input  wire logic [15:0] i_latch_events,
    input  wire logic [15:0] i_pin_readback,
    output logic             o_error_insert,
    output logic             o_monitor_update,
    output logic             o_datapath_reset,
    output logic             o_ctrl_reset,
    output logic             o_ref8k,
    output logic             o_ref8k_enable,
    output logic             o_ref8k_output_select,
    output logic      [2:0]  o_rate_adapter_ref_select,
    output logic      [15:0] o_general_pin_control
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] ctrl1_r;
    logic [15:0] ctrl2_r;
    logic [15:0] pinctl_r;
    logic [15:0] ien_r;
    logic [15:0] sien_r;
    logic [15:0] latch_r;
    logic [15:0] latch_nxt;
    logic [1:0]  irq_sync_r;
    logic [1:0]  p4_sync_r;
    logic [1:0]  p6_sync_r;
    logic [1:0]  p8_sync_r;
    logic [1:0]  port_sync_r;
    logic [1:0]  adpt_sync_r;
    logic [1:0]  done_sync_r;
    logic        p6_prev_r;
    logic        p8_prev_r;
    logic        trig_prev_r;
    logic        req_prev_r;
    logic        sec_tick_r;
    logic [12:0] sec_cnt_r;
    logic        ref_prev_r;
    logic        done_r;
    gcr_pkg::gcr_hs_state_t hs_r;
    logic        full_rst;
    logic        ref_sel;
    logic        wr_c1;
    logic [15:0] rdata_nxt;
    gcr_pkg::gcr_upd_src_t upd_src;

    assign full_rst = ctrl1_r[`GCR_C1_FULL_RST];
    assign wr_c1    = i_wr && (i_addr == `GCR_OFS_CTRL1);
    assign upd_src  = ctrl1_r[`GCR_C1_MODE_HI] ? gcr_pkg::GCR_UPD_SEC :
                      (ctrl1_r[`GCR_C1_MODE_LO] ? gcr_pkg::GCR_UPD_PIN
                                                 : gcr_pkg::GCR_UPD_SOFT);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops each
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_sync_r  <= 2'h0;
            p4_sync_r   <= 2'h0;
            p6_sync_r   <= 2'h0;
            p8_sync_r   <= 2'h0;
            port_sync_r <= 2'h0;
            adpt_sync_r <= 2'h0;
            done_sync_r <= 2'h0;
        end
        else
        begin
            irq_sync_r  <= {irq_sync_r[0], i_irq_active};
            p4_sync_r   <= {p4_sync_r[0], i_aux_pin_four};
            p6_sync_r   <= {p6_sync_r[0], i_aux_pin_six};
            p8_sync_r   <= {p8_sync_r[0], i_aux_pin_eight};
            port_sync_r <= {port_sync_r[0], i_port_ref8k};
            adpt_sync_r <= {adpt_sync_r[0], i_adapter_ref8k};
            done_sync_r <= {done_sync_r[0], i_monitor_update_done};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control one; full reset loads defaults into all but itself
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            ctrl1_r <= `GCR_C1_RESET;                                // see [R13]
        else if (wr_c1)
            ctrl1_r <= i_wdata & `GCR_C1_MASK;
        else if (full_rst)
            ctrl1_r <= `GCR_C1_RESET | (16'h0001 << `GCR_C1_FULL_RST); // see [R14]
    end

    // Other writable registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ctrl2_r  <= `GCR_C2_RESET;
            pinctl_r <= `GCR_ZERO16;
            ien_r    <= `GCR_ZERO16;
            sien_r   <= `GCR_ZERO16;
        end
        else if (full_rst)
        begin
            ctrl2_r  <= `GCR_C2_RESET;                               // see [R14]
            pinctl_r <= `GCR_ZERO16;
            ien_r    <= `GCR_ZERO16;
            sien_r   <= `GCR_ZERO16;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `GCR_OFS_CTRL2:  ctrl2_r  <= i_wdata & `GCR_C2_MASK;
                `GCR_OFS_PINCTL: pinctl_r <= i_wdata;
                `GCR_OFS_IEN:    ien_r    <= i_wdata;
                `GCR_OFS_SIEN:   sien_r   <= i_wdata;
                default:         ;                                   // see [R21]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched status: set wins over clear, clear per policy
    always_comb
    begin
        latch_nxt = latch_r;
        if (i_addr == `GCR_OFS_LATCH)
        begin
            if (ctrl1_r[`GCR_C1_CLR_POL] && i_rd)
                latch_nxt = latch_r & ~rdata_nxt;                    // see [R11]
            else if (!ctrl1_r[`GCR_C1_CLR_POL] && i_wr)
                latch_nxt = latch_r & ~i_wdata;                      // see [R11]
        end
        latch_nxt = latch_nxt | i_latch_events;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            latch_r <= `GCR_ZERO16;
        else if (full_rst)
            latch_r <= `GCR_ZERO16;                                  // see [R14]
        else
            latch_r <= latch_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        case (i_addr)
            `GCR_OFS_IDENT:  rdata_nxt = {SCAN_REVISION, SCAN_PART};  // see [R1] [R2]
            `GCR_OFS_CTRL1:  rdata_nxt = ctrl1_r;
            `GCR_OFS_CTRL2:  rdata_nxt = ctrl2_r;
            `GCR_OFS_PINCTL: rdata_nxt = pinctl_r;
            `GCR_OFS_ISTAT:  rdata_nxt = i_interrupt_status;
            `GCR_OFS_IEN:    rdata_nxt = ien_r;
            `GCR_OFS_LIVE:   rdata_nxt = i_live_status | {15'h0000, done_r};
            `GCR_OFS_LATCH:  rdata_nxt = latch_r;
            `GCR_OFS_SIEN:   rdata_nxt = sien_r;
            `GCR_OFS_PINRD:  rdata_nxt = i_pin_readback;
            default:         rdata_nxt = `GCR_ZERO16;                // see [R21]
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_rdata <= `GCR_ZERO16;
        else if (i_rd)
            o_rdata <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin: low when active, idle drive per control
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq_out <= 1'b0;
            o_irq_oe  <= 1'b0;
        end
        else
        begin
            o_irq_out <= !irq_sync_r[1];                             // see [R3]
            o_irq_oe  <= irq_sync_r[1] || ctrl1_r[`GCR_C1_IRQ_IDLE]; // see [R3] [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Manual error insertion
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            trig_prev_r    <= 1'b0;
            p6_prev_r      <= 1'b0;
            o_error_insert <= 1'b0;
        end
        else
        begin
            trig_prev_r <= ctrl1_r[`GCR_C1_MAN_ERR];
            p6_prev_r   <= p6_sync_r[1];
            if (ctrl1_r[`GCR_C1_ERR_SRC])
                o_error_insert <= p6_sync_r[1] && !p6_prev_r;        // see [R7]
            else
                o_error_insert <= ctrl1_r[`GCR_C1_MAN_ERR] && !trig_prev_r; // see [R5] [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor update source and handshake
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            req_prev_r       <= 1'b0;
            p8_prev_r        <= 1'b0;
            o_monitor_update <= 1'b0;
        end
        else
        begin
            req_prev_r <= ctrl1_r[`GCR_C1_UPD_REQ];
            p8_prev_r  <= p8_sync_r[1];
            case (upd_src)                                           // see [R8]
                gcr_pkg::GCR_UPD_SOFT:
                    o_monitor_update <= ctrl1_r[`GCR_C1_UPD_REQ] && !req_prev_r; // see [R9]
                gcr_pkg::GCR_UPD_PIN:
                    o_monitor_update <= p8_sync_r[1] && !p8_prev_r;
                default:
                    o_monitor_update <= sec_tick_r;
            endcase
        end
    end

    // Done flag: set by counters, cleared when request falls
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hs_r   <= gcr_pkg::GCR_HS_IDLE;
            done_r <= 1'b0;
        end
        else if (full_rst)
        begin
            hs_r   <= gcr_pkg::GCR_HS_IDLE;
            done_r <= 1'b0;
        end
        else
        begin
            case (hs_r)
                gcr_pkg::GCR_HS_IDLE:
                    if (o_monitor_update)
                        hs_r <= gcr_pkg::GCR_HS_BUSY;
                gcr_pkg::GCR_HS_BUSY:
                    if (done_sync_r[1])
                    begin
                        hs_r   <= gcr_pkg::GCR_HS_DONE;
                        done_r <= 1'b1;
                    end
                gcr_pkg::GCR_HS_DONE:
                    if (!ctrl1_r[`GCR_C1_UPD_REQ] || upd_src != gcr_pkg::GCR_UPD_SOFT)
                    begin
                        hs_r   <= gcr_pkg::GCR_HS_IDLE;
                        done_r <= 1'b0;                              // see [R10]
                    end
                default:
                    hs_r <= gcr_pkg::GCR_HS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 8 kHz reference select and one-second divider
    always_comb
    begin
        if (ctrl2_r[`GCR_C2_EXT_SEL])
            ref_sel = p4_sync_r[1];                                  // see [R17] [R19]
        else
        begin
            case (ctrl2_r[`GCR_C2_SRC_HI:`GCR_C2_SRC_LO])            // see [R16] [R18]
                2'h1:    ref_sel = adpt_sync_r[1];
                2'h2:    ref_sel = port_sync_r[1];
                default: ref_sel = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ref_prev_r <= 1'b0;
            sec_cnt_r  <= 13'h0000;
            sec_tick_r <= 1'b0;
            o_ref8k    <= 1'b0;
        end
        else
        begin
            ref_prev_r <= ref_sel;
            o_ref8k    <= ref_sel;
            sec_tick_r <= 1'b0;
            if (ref_sel && !ref_prev_r)                              // see [R16]
            begin
                if (sec_cnt_r == 13'h1f3f)
                begin
                    sec_cnt_r  <= 13'h0000;
                    sec_tick_r <= 1'b1;
                end
                else
                    sec_cnt_r <= sec_cnt_r + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs to data path and clocking
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_datapath_reset          <= 1'b1;
            o_ctrl_reset              <= 1'b0;
            o_ref8k_enable            <= 1'b0;
            o_ref8k_output_select     <= 1'b0;
            o_rate_adapter_ref_select <= 3'h0;
            o_general_pin_control     <= `GCR_ZERO16;
        end
        else
        begin
            o_datapath_reset <= ctrl1_r[`GCR_C1_DP_RST] || full_rst; // see [R12] [R14] [R15]
            o_ctrl_reset     <= full_rst;                            // see [R14]
            o_ref8k_enable   <= ctrl2_r[`GCR_C2_EXT_SEL] ||
                                (ctrl2_r[`GCR_C2_SRC_HI:`GCR_C2_SRC_LO] != 2'h0);
            o_ref8k_output_select     <= ctrl2_r[`GCR_C2_OUT_SEL];
            o_rate_adapter_ref_select <= ctrl2_r[`GCR_C2_RATE_HI:`GCR_C2_RATE_LO]; // see [R20]
            o_general_pin_control     <= pinctl_r;
        end
    end
endmodule : gcr_bank
`default_nettype wire

// *** verif/gcr_bank_sva.sv ***
`include "gcr_cfg.svh"
`default_nettype none
module gcr_bank_sva
#(
    parameter logic [3:0]  SCAN_REVISION = 4'h1,
    parameter logic [11:0] SCAN_PART     = 12'h0a5
)
(
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic [7:0]  i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic        i_irq_active,
    input wire logic        o_irq_out,
    input wire logic        o_irq_oe,
    input wire logic        i_aux_pin_six,
    input wire logic        i_aux_pin_eight,
    input wire logic        o_error_insert,
    input wire logic        o_monitor_update,
    input wire logic        o_datapath_reset,
    input wire logic        o_ctrl_reset
);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [15:0] c1_r;
    logic        wc1;
    ////////////////////////////////////////////////////////////
    // Shadow of control one as the host wrote it
    assign wc1 = i_wr && i_addr == `GCR_OFS_CTRL1;
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            c1_r <= `GCR_C1_RESET;
        else if (wc1)
            c1_r <= i_wdata & `GCR_C1_MASK;
    end
    ////////////////////////////////////////////////////////////
    // Reads, interrupt pin, pulses and reset levels
    ident_rd_a: assert property (
        i_rd && i_addr == 8'h00 |=> o_rdata == {SCAN_REVISION, SCAN_PART})
        else $error("identity read wrong");
    unmap_rd_a: assert property (
        i_rd && !(i_addr inside {8'h00, 8'h02, 8'h04, 8'h0a, 8'h10, 8'h12, 8'h14, 8'h16,
        8'h18, 8'h1c}) |=> o_rdata == 16'h0000)
        else $error("unused address read not zero");
    irq_low_a: assert property (i_irq_active [*4] |-> o_irq_oe && !o_irq_out)
        else $error("interrupt pin not low while active");
    irq_idle_a: assert property (
        (!i_irq_active && $stable(c1_r[14])) [*5] |-> o_irq_oe == c1_r[14]
        && (o_irq_out || !o_irq_oe))
        else $error("interrupt idle drive wrong");
    err_trig_a: assert property (
        wc1 && i_wdata[7] && !i_wdata[6] && !c1_r[7] |-> ##2 o_error_insert)
        else $error("trigger edge gave no error pulse");
    err_block_a: assert property (
        !i_aux_pin_six [*5] ##0 (wc1 && i_wdata[7] && i_wdata[6]) |-> ##2 !o_error_insert)
        else $error("trigger acted with pin source chosen");
    err_pin_a: assert property (
        $rose(i_aux_pin_six) && c1_r[6] |-> ##[3:5] o_error_insert)
        else $error("pin six edge gave no error pulse");
    upd_soft_a: assert property (
        wc1 && i_wdata[3] && i_wdata[5:4] == 2'b00 && !c1_r[3] |-> ##2 o_monitor_update)
        else $error("soft update edge gave no pulse");
    upd_pin_a: assert property (
        $rose(i_aux_pin_eight) && c1_r[5:4] == 2'b01 |-> ##[3:5] o_monitor_update)
        else $error("pin eight edge gave no pulse");
    dp_rst_a: assert property (
        ($stable(c1_r[1]) && !c1_r[0]) [*3] |-> o_datapath_reset == c1_r[1])
        else $error("datapath reset level wrong");
    full_rst_a: assert property (c1_r[0] [*3] |-> o_ctrl_reset)
        else $error("full reset not applied");
endmodule : gcr_bank_sva
`default_nettype wire

// *** verif/gcr_host_model.sv ***
`default_nettype none
module gcr_host_model
(
    input  wire logic        i_sys_clk,
    input  wire logic [15:0] i_rdata,
    output logic      [7:0]  o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle from time zero
    initial
    begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end
    // Strobe held for one sampling edge, then a gap edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_sys_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        @(posedge i_sys_clk);
    endtask : wr
    // Data taken one edge after the read edge
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_sys_clk);
        o_rd   <= 1'b0;
        @(posedge i_sys_clk);
        q = i_rdata;
    endtask : rd
endmodule : gcr_host_model
`default_nettype wire

// *** verif/tb_gcr_bank.sv ***
`include "gcr_cfg.svh"
`default_nettype none
module tb_gcr_bank;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0]  REV  = 4'h6;    // Arbitrary value
    localparam logic [11:0] PART = 12'h3c9; // Arbitrary value
    logic        i_sys_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [7:0]  i_addr;
    logic        i_wr, i_rd;
    logic [15:0] i_wdata, o_rdata, o_general_pin_control, q;
    logic        i_irq_active = 1'b0, i_aux_pin_four = 1'b0, i_aux_pin_six = 1'b0;
    logic        i_aux_pin_eight = 1'b0, i_port_ref8k = 1'b0, i_adapter_ref8k = 1'b0;
    logic        i_monitor_update_done = 1'b0;
    logic [15:0] i_interrupt_status = 16'h1234, i_live_status = 16'h8000;
    logic [15:0] i_latch_events = 16'h0000, i_pin_readback = 16'h4321;
    logic        o_irq_out, o_irq_oe, o_error_insert, o_monitor_update, o_ref8k;
    logic        o_datapath_reset, o_ctrl_reset, o_ref8k_enable, o_ref8k_output_select;
    logic [2:0]  o_rate_adapter_ref_select;
    logic [7:0]  unm [7] = '{8'h06, 8'h08, 8'h0c, 8'h0e, 8'h1a, 8'h1e, 8'h40};
    logic [15:0] rsel [3] = '{16'h0400, 16'h0800, 16'h0500};
    int          bad_count = 0, checks_done = 0, err_n = 0, upd_n = 0, e0;
    gcr_bank #(.SCAN_REVISION(REV), .SCAN_PART(PART)) dut (.*);
    gcr_host_model host (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
                         .o_rd(i_rd), .o_wdata(i_wdata));
    ////////////////////////////////////////////////////////////
    // Clock and pulse counters
    always #20 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk)
    begin
        err_n <= err_n + int'(o_error_insert === 1'b1);
        upd_n <= upd_n + int'(o_monitor_update === 1'b1);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        host.rd(a, q);
        chk(q, exp);
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : cyc
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Hang guard
    initial
    begin
        #100us;
        bad_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        cyc(2);
        i_reset_n <= 1'b1;
        cyc(1);
        rdc(8'h00, {REV, PART});
        host.wr(8'h00, 16'hffff);
        rdc(8'h00, {REV, PART});
        rdc(8'h02, `GCR_C1_RESET);
        chk(16'(o_datapath_reset), 16'h0001);
        rdc(8'h10, 16'h1234);
        rdc(8'h1c, 16'h4321);
        host.wr(8'h12, 16'h5a5a);
        rdc(8'h12, 16'h5a5a);
        foreach (unm[i])
        begin
            host.wr(unm[i], 16'hffff);
            rdc(unm[i], 16'h0000);
        end
        host.wr(8'h04, 16'hffff);
        rdc(8'h04, `GCR_C2_MASK);
        for (int c = 0; c < 5; c++)
        begin
            host.wr(8'h04, {12'h000, c[2:0], 1'b0});
            cyc(1);
            chk(16'(o_rate_adapter_ref_select), 16'(c));
        end
        $display("test map done");
        // Reference follows only the chosen source
        for (int i = 0; i < 3; i++)
        begin
            host.wr(8'h04, rsel[i]);
            for (int v = 0; v < 2; v++)
            begin
                i_adapter_ref8k <= v[0] ^ (i != 0);
                i_port_ref8k    <= v[0] ^ (i != 1);
                i_aux_pin_four  <= v[0] ^ (i != 2);
                cyc(5);
                chk(16'(o_ref8k), 16'(v));
            end
        end
        host.wr(8'h04, 16'h0000);
        cyc(5);
        chk(16'(o_ref8k_enable), 16'h0000);
        chk(16'(o_ref8k), 16'h0000);
        $display("test reference done");
        // Interrupt pin
        host.wr(8'h02, 16'h4000);
        cyc(4);
        chk({14'h0, o_irq_oe, o_irq_out}, 16'h0003);
        i_irq_active <= 1'b1;
        cyc(4);
        chk({14'h0, o_irq_oe, o_irq_out}, 16'h0002);
        host.wr(8'h02, 16'h0000);
        cyc(4);
        chk({14'h0, o_irq_oe, o_irq_out}, 16'h0002);
        i_irq_active <= 1'b0;
        cyc(4);
        chk(16'(o_irq_oe), 16'h0000);
        $display("test interrupt done");
        // Manual error insertion
        e0 = err_n;
        host.wr(8'h02, 16'h0080);
        host.wr(8'h02, 16'h0000);
        host.wr(8'h02, 16'h00c0);
        cyc(4);
        chk(16'(err_n - e0), 16'h0001);
        i_aux_pin_six <= 1'b1;
        cyc(8);
        i_aux_pin_six <= 1'b0;
        host.wr(8'h02, 16'h0000);
        i_aux_pin_six <= 1'b1;
        cyc(8);
        i_aux_pin_six <= 1'b0;
        chk(16'(err_n - e0), 16'h0002);
        $display("test error done");
        // Update handshake, then pin and one-second modes
        e0 = upd_n;
        host.wr(8'h02, 16'h0008);
        cyc(3);
        i_monitor_update_done <= 1'b1;
        cyc(4);
        rdc(8'h14, 16'h8001);
        i_monitor_update_done <= 1'b0;
        cyc(4);
        rdc(8'h14, 16'h8001);
        host.wr(8'h02, 16'h0000);
        cyc(2);
        rdc(8'h14, 16'h8000);
        chk(16'(upd_n - e0), 16'h0001);
        for (int m = 1; m < 3; m++)
        begin
            host.wr(8'h02, {10'h000, m[1:0], 4'h0});
            i_aux_pin_eight <= 1'b1;
            host.wr(8'h02, {10'h000, m[1:0], 4'h8});
            cyc(8);
            i_aux_pin_eight <= 1'b0;
            host.wr(8'h02, 16'h0000);
        end
        chk(16'(upd_n - e0), 16'h0002);
        $display("test update done");
        // Latched status clear policy
        for (int p = 0; p < 2; p++)
        begin
            host.wr(8'h02, {13'h0000, p[0], 2'b00});
            i_latch_events <= 16'h0020;
            cyc(1);
            i_latch_events <= 16'h0000;
            host.wr(8'h16, 16'h0020);
            rdc(8'h16, p[0] ? 16'h0020 : 16'h0000);
            rdc(8'h16, 16'h0000);
        end
        $display("test latched done");
        // Data-path and full resets
        host.wr(8'h02, 16'h0002);
        cyc(1);
        chk(16'(o_datapath_reset), 16'h0001);
        host.wr(8'h04, 16'h0f0e);
        host.wr(8'h0a, 16'h5a5a);
        rdc(8'h0a, 16'h5a5a);
        chk(o_general_pin_control, 16'h5a5a);
        chk(16'(o_ref8k_output_select), 16'h0001);
        host.wr(8'h02, 16'h0001);
        cyc(`GCR_RST_HOLD_CYC);
        chk(16'(o_ctrl_reset), 16'h0001);
        host.rd(8'h02, q);
        chk(16'(q[0]), 16'h0001);
        rdc(8'h04, `GCR_C2_RESET);
        host.wr(8'h02, 16'h0000);
        cyc(1);
        chk(16'(o_datapath_reset), 16'h0000);
        rdc(8'h0a, 16'h0000);
        chk(o_general_pin_control, 16'h0000);
        chk(16'(o_ref8k_output_select), 16'h0000);
        $display("test reset done");
        close_out();
    end
endmodule : tb_gcr_bank
bind gcr_bank gcr_bank_sva #(.SCAN_REVISION(SCAN_REVISION), .SCAN_PART(SCAN_PART)) u_sva (.*);
`default_nettype wire
